// >>> rtl/cba_consts.vh
// Function
// - block fill writes one location every two character clocks
// - block fill runs only in blanking, spanning as many intervals as needed
// - immediate commands accepted at any time regardless of ready flag
// - on request raise acknowledge, release buses, then lower acknowledge to grant; shared mode releases and lowers in the same clock
// - transparent mode grants only when a blanking interval begins
// - shared mode blanks display and grants immediately
// - request removed after next-to-last blank clock blanks next line too
// - requests during vertical blank or display off granted at front porch start
// - row table enabled delays host access two clocks before row line 0
// - row buffer mode halts host on line 0 and copies next row
// - row bus request warns of next blank fall; high again after row moved
// - table entry two bytes: low 8 bits, then upper 6 bits
// - top two bits are double attributes or extra address bits, per enable
// - table fetch in blank before each row loads start, pointer plus two
// - cursor output asserted during blank while a table fetch runs
// - device inactive after power-up until two successive master resets
// - fifteen init registers share one address; pointer advances, sticks at last
// - power-on or master reset zeroes pointer; load command presets it
// - init registers write only; reads do not return contents
// - buffer mode chosen by two lowest bits of first init register
`ifndef CBA_CONSTS_VH
`define CBA_CONSTS_VH
`define CBA_ADDR_INIT 3'h0
`define CBA_ADDR_CMD 3'h1
`define CBA_ADDR_SS1_LO 3'h2
`define CBA_ADDR_SS1_HI 3'h3
`define CBA_ADDR_CUR_LO 3'h4
`define CBA_ADDR_CUR_HI 3'h5
`define CBA_ADDR_SS2_LO 3'h6
`define CBA_ADDR_SS2_HI 3'h7
`define CBA_ADDR_STATUS 3'h1
`define CBA_ADDR_PTR_LO 3'h0
`define CBA_CMD_MASTER_RESET 8'h00
`define CBA_CMD_LOAD_IRP_HI 4'h1
`define CBA_CMD_BLOCK_FILL 8'hbb
`define CBA_CMD_DISPLAY_ON 8'h3d
`define CBA_CMD_DISPLAY_OFF 8'h3c
`define CBA_CMD_PTR_LO 8'h1a
`define CBA_CMD_PTR_HI 8'h1b
`define CBA_NUM_IR 4'hf
`define CBA_IR_LAST 4'he
`define CBA_MODE_INDEP 2'h0
`define CBA_MODE_TRANSP 2'h1
`define CBA_MODE_SHARED 2'h2
`define CBA_MODE_ROWBUF 2'h3
`define CBA_IR0_MODE_LSB 0
`define CBA_IR0_DOUBLE_BIT 7
`define CBA_IR2_ROWTAB_BIT 7
`define CBA_FILL_PERIOD 2'h2
`define CBA_ROWTAB_DELAY 2'h2
`define CBA_RESET_COUNT 2'h2
`define CBA_ST_READY_BIT 5
`define CBA_ST_ACTIVE_BIT 7
`endif

// >>> rtl/cba_arbiter.v
`timescale 1ns/1ps
`include "cba_consts.vh"
module cba_arbiter #(
	parameter AW = 16
) (
	input wire CLOCK,
	input wire RESET,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	output reg [7:0] RDATA,
	input wire BLANK_IN,
	input wire VBLANK_IN,
	input wire HBLANK_LAST2_IN,
	input wire HFP_START_IN,
	input wire ROW_LINE0_IN,
	input wire ROW_NEXT_IN,
	input wire LAST_LINE_IN,
	input wire HOST_BUFFER_REQUEST,
	input wire [7:0] MEM_RDATA,
	output reg BACK,
	output reg BUS_RELEASE_OUT,
	output reg ROWBUF_BUS_REQUEST,
	output reg ROWBUF_CLOCK,
	output reg BLANK_FORCE,
	output reg CURSOR,
	output reg LAST_LINE_MUX_PIN,
	output reg MEM_WE,
	output reg MEM_RE,
	output reg [AW-1:0] MEM_ADDR,
	output reg [7:0] MEM_WDATA,
	output reg ACTIVE
);
	localparam S_IDLE = 3'h0;
	localparam S_ACK = 3'h1;
	localparam S_GRANT = 3'h2;
	localparam S_HOLD = 3'h3;
	localparam S_ROWDMA = 3'h4;
	localparam S_TBL0 = 3'h5;
	localparam S_TBL1 = 3'h6;
	localparam S_TBLDONE = 3'h7;

	reg [1:0] rq_s;
	reg [1:0] bl_s;
	reg bl_d;
	reg hb_req;
	reg [7:0] ir [0:14];
	reg [3:0] irp;
	reg [1:0] mr_cnt;
	reg disp_on;
	reg [15:0] ss1;
	reg [15:0] ss2;
	reg [15:0] cur;
	reg [15:0] ptr;
	reg fill_busy;
	reg fill_ph;
	reg [2:0] st;
	reg [1:0] dly;
	reg [7:0] tbl_lo;
	reg blank_next_line;
	reg [7:0] rowcnt;
	integer i;

	wire req = rq_s[1];
	wire blank = bl_s[1];
	wire blank_rise = blank & ~bl_d;
	wire [1:0] mode = ir[0][`CBA_IR0_MODE_LSB+1:`CBA_IR0_MODE_LSB];
	wire rowtab_en = ir[2][`CBA_IR2_ROWTAB_BIT];
	wire dbl_en = ir[0][`CBA_IR0_DOUBLE_BIT];
	wire host_free = (st == S_IDLE) | (st == S_ACK);
	wire [15:0] tbl_addr = {MEM_RDATA, tbl_lo};

	function is_wr;
		input [2:0] a;
		input [2:0] want;
		input w;
		begin
			is_wr = w & (a == want);
		end
	endfunction

	// blank and host request pins pass two flops; last line passes one flop to its pin; the other display timing pins are used directly
	always @(posedge CLOCK) begin
		rq_s <= {rq_s[0], HOST_BUFFER_REQUEST};
		bl_s <= {bl_s[0], BLANK_IN};
		bl_d <= blank;
	end

	// grant window: transparent needs request at blank rise
	always @(posedge CLOCK) begin
		if (RESET)
			hb_req <= 1'b0;
		else if (blank_rise)
			hb_req <= req;
		else if (!blank)
			hb_req <= 1'b0;
	end

	// command and register port
	always @(posedge CLOCK) begin
		if (RESET) begin
			irp <= 4'h0;
			mr_cnt <= 2'h0;
			ACTIVE <= 1'b0;
			disp_on <= 1'b0;
			ss1 <= 16'h0000;
			ss2 <= 16'h0000;
			cur <= 16'h0000;
			ptr <= 16'h0000;
			fill_busy <= 1'b0;
			fill_ph <= 1'b0;
			MEM_WE <= 1'b0;
			MEM_WDATA <= 8'h00;
			RDATA <= 8'h00;
			for (i = 0; i < 15; i = i + 1)
				ir[i] <= 8'h00;
		end else begin
			MEM_WE <= 1'b0;
			if (RD) begin
				// init regs are write only; address 0 reads the pointer
				case (ADDR)
				`CBA_ADDR_PTR_LO: RDATA <= {4'h0, irp};
				`CBA_ADDR_STATUS: RDATA <= {ACTIVE, 1'b0, ~fill_busy, 5'h00};
				`CBA_ADDR_SS1_LO: RDATA <= ss1[7:0];
				`CBA_ADDR_SS1_HI: RDATA <= ss1[15:8];
				`CBA_ADDR_CUR_LO: RDATA <= cur[7:0];
				`CBA_ADDR_CUR_HI: RDATA <= cur[15:8];
				`CBA_ADDR_SS2_LO: RDATA <= ss2[7:0];
				`CBA_ADDR_SS2_HI: RDATA <= ss2[15:8];
				default: RDATA <= 8'h00;
				endcase
			end
			if (is_wr(ADDR, `CBA_ADDR_INIT, WR) && ACTIVE) begin
				ir[irp] <= WDATA;
				if (irp != `CBA_IR_LAST)
					irp <= irp + 4'h1;
			end
			// commands decoded regardless of ready state
			if (is_wr(ADDR, `CBA_ADDR_CMD, WR)) begin
				if (WDATA == `CBA_CMD_MASTER_RESET) begin
					irp <= 4'h0;
					fill_busy <= 1'b0;
					disp_on <= 1'b0;
					if (mr_cnt == `CBA_RESET_COUNT - 2'h1)
						ACTIVE <= 1'b1;
					else
						mr_cnt <= mr_cnt + 2'h1;
				end else begin
					// any other command breaks a pair of resets, even while inactive
					mr_cnt <= 2'h0;
					if (ACTIVE && WDATA[7:4] == `CBA_CMD_LOAD_IRP_HI)
						irp <= (WDATA[3:0] > `CBA_IR_LAST) ? `CBA_IR_LAST : WDATA[3:0];
					else if (ACTIVE && WDATA == `CBA_CMD_DISPLAY_ON)
						disp_on <= 1'b1;
					else if (ACTIVE && WDATA == `CBA_CMD_DISPLAY_OFF)
						disp_on <= 1'b0;
					else if (ACTIVE && WDATA == `CBA_CMD_BLOCK_FILL)
						fill_busy <= 1'b1;
				end
			end else if (WR)
				mr_cnt <= 2'h0;
			if (ACTIVE) begin
				if (is_wr(ADDR, `CBA_ADDR_SS1_LO, WR))
					ss1[7:0] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_SS1_HI, WR)) begin
					ss1[15:8] <= WDATA;
					if (dbl_en)
						ir[14][7:6] <= WDATA[7:6];
				end
				if (is_wr(ADDR, `CBA_ADDR_CUR_LO, WR))
					cur[7:0] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_CUR_HI, WR))
					cur[15:8] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_SS2_LO, WR))
					ss2[7:0] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_SS2_HI, WR))
					ss2[15:8] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_CMD, WR) && WDATA == `CBA_CMD_PTR_LO)
					ptr[7:0] <= WDATA;
				if (is_wr(ADDR, `CBA_ADDR_CMD, WR) && WDATA == `CBA_CMD_PTR_HI)
					ptr[15:8] <= WDATA;
			end
			// fill pauses outside blank and resumes next interval
			if (fill_busy && blank && host_free) begin
				fill_ph <= ~fill_ph;
				if (!fill_ph) begin
					MEM_WE <= 1'b1;
					MEM_WDATA <= ir[1];
					// a fill command landing in the finishing cycle is not lost
					if (cur == ptr)
						fill_busy <= ACTIVE && is_wr(ADDR, `CBA_ADDR_CMD, WR) &&
							WDATA == `CBA_CMD_BLOCK_FILL;
					else
						cur <= cur + 16'h0001;
				end
			end else
				fill_ph <= 1'b0;
			// table fetch: load start register, step table pointer
			if (st == S_TBL1) begin
				ss1 <= dbl_en ? {2'h0, MEM_RDATA[5:0], tbl_lo} : tbl_addr;
				if (dbl_en)
					ir[14][7:6] <= MEM_RDATA[7:6];
				ss2 <= ss2 + 16'h0002;
			end
		end
	end

	// access arbitration and row fetch sequencer
	always @(posedge CLOCK) begin
		if (RESET) begin
			st <= S_IDLE;
			dly <= 2'h0;
			tbl_lo <= 8'h00;
			BACK <= 1'b0;
			BUS_RELEASE_OUT <= 1'b0;
			ROWBUF_BUS_REQUEST <= 1'b1;
			ROWBUF_CLOCK <= 1'b0;
			BLANK_FORCE <= 1'b0;
			CURSOR <= 1'b0;
			MEM_RE <= 1'b0;
			MEM_ADDR <= {AW{1'b0}};
			LAST_LINE_MUX_PIN <= 1'b0;
			blank_next_line <= 1'b0;
			rowcnt <= 8'h00;
		end else begin
			LAST_LINE_MUX_PIN <= LAST_LINE_IN;
			ROWBUF_CLOCK <= 1'b0;
			MEM_RE <= 1'b0;
			CURSOR <= 1'b0;
			if (dly != 2'h0)
				dly <= dly - 2'h1;
			if (HBLANK_LAST2_IN && req && st == S_GRANT)
				blank_next_line <= 1'b1;
			case (st)
			S_IDLE: begin
				if (ACTIVE && rowtab_en && disp_on && blank && ROW_NEXT_IN) begin
					st <= S_TBL0;
					MEM_ADDR <= ss2[AW-1:0];
					MEM_RE <= 1'b1;
					CURSOR <= 1'b1;
					dly <= `CBA_ROWTAB_DELAY;
				end else if (ACTIVE && mode == `CBA_MODE_ROWBUF && ROW_NEXT_IN && blank) begin
					ROWBUF_BUS_REQUEST <= 1'b0;
					st <= S_HOLD;
				end else if (ACTIVE && req && dly == 2'h0 &&
						(mode == `CBA_MODE_SHARED || mode == `CBA_MODE_TRANSP)) begin
					BACK <= 1'b1;
					st <= S_ACK;
				end
			end
			S_ACK: begin
				BUS_RELEASE_OUT <= 1'b1;
				if (!req) begin
					BACK <= 1'b0;
					BUS_RELEASE_OUT <= 1'b0;
					st <= S_IDLE;
				end else if (mode == `CBA_MODE_SHARED) begin
					BLANK_FORCE <= 1'b1;
					BACK <= 1'b0;
					st <= S_GRANT;
				end else if ((VBLANK_IN || !disp_on) ? HFP_START_IN : hb_req) begin
					BACK <= 1'b0;
					st <= S_GRANT;
				end
			end
			S_GRANT: begin
				if (!req) begin
					BUS_RELEASE_OUT <= 1'b0;
					BLANK_FORCE <= blank_next_line;
					st <= S_IDLE;
				end else if (mode == `CBA_MODE_TRANSP && !blank && !VBLANK_IN) begin
					// access ran past the interval: next line blanked too
					blank_next_line <= 1'b1;
				end
			end
			S_HOLD: begin
				if (ROW_LINE0_IN && !blank) begin
					ROWBUF_CLOCK <= 1'b1;
					MEM_ADDR <= ss1[AW-1:0];
					MEM_RE <= 1'b1;
					rowcnt <= 8'h01;
					st <= S_ROWDMA;
				end
			end
			S_ROWDMA: begin
				if (blank || !ROW_LINE0_IN) begin
					ROWBUF_BUS_REQUEST <= 1'b1;
					st <= S_IDLE;
				end else begin
					ROWBUF_CLOCK <= 1'b1;
					MEM_RE <= 1'b1;
					MEM_ADDR <= ss1[AW-1:0] + {{(AW-8){1'b0}}, rowcnt};
					rowcnt <= rowcnt + 8'h01;
				end
			end
			S_TBL0: begin
				CURSOR <= 1'b1;
				tbl_lo <= MEM_RDATA;
				MEM_ADDR <= ss2[AW-1:0] + {{(AW-1){1'b0}}, 1'b1};
				MEM_RE <= 1'b1;
				st <= S_TBL1;
			end
			S_TBL1: begin
				CURSOR <= 1'b1;
				st <= S_TBLDONE;
			end
			S_TBLDONE: begin
				if (!ROW_NEXT_IN)
					st <= S_IDLE;
			end
			default: st <= S_IDLE;
			endcase
			if (st != S_GRANT && !blank)
				blank_next_line <= 1'b0;
			if (st == S_IDLE && !req && !blank)
				BLANK_FORCE <= 1'b0;
		end
	end
endmodule // cba_arbiter

// >>> bench/cba_props.sv
`timescale 1ns/1ps
module cba_props (
	input wire CLOCK,
	input wire RESET,
	input wire [2:0] ADDR,
	input wire [7:0] WDATA,
	input wire WR,
	input wire RD,
	input wire [7:0] RDATA,
	input wire BLANK_IN,
	input wire LAST_LINE_IN,
	input wire HOST_BUFFER_REQUEST,
	input wire BACK,
	input wire BUS_RELEASE_OUT,
	input wire ROWBUF_BUS_REQUEST,
	input wire ROWBUF_CLOCK,
	input wire LAST_LINE_MUX_PIN,
	input wire MEM_WE,
	input wire ACTIVE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	property p_active;
		$rose(ACTIVE) |-> $past(WR && ADDR == 3'h1 && WDATA == 8'h00);
	endproperty
	a_active: assert property (p_active) else $error("active without reset command");
	property p_fill_gap;
		MEM_WE |=> !MEM_WE;
	endproperty
	a_fill_gap: assert property (p_fill_gap) else $error("fill writes too close");
	// blank passes a two flop synchroniser first
	property p_fill_blank;
		MEM_WE |-> $past(BLANK_IN, 2) || $past(BLANK_IN, 3) || $past(BLANK_IN, 4);
	endproperty
	a_fill_blank: assert property (p_fill_blank) else $error("fill write outside blank");
	property p_ack_rel;
		$rose(BACK) |=> BUS_RELEASE_OUT;
	endproperty
	a_ack_rel: assert property (p_ack_rel) else $error("buses not released after ack");
	property p_grant;
		$fell(BACK) |-> BUS_RELEASE_OUT;
	endproperty
	a_grant: assert property (p_grant) else $error("grant with buses held");
	property p_ack_cause;
		$rose(BACK) |-> $past(HOST_BUFFER_REQUEST, 3) || $past(HOST_BUFFER_REQUEST, 4);
	endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	property p_rowclk;
		ROWBUF_CLOCK |-> !ROWBUF_BUS_REQUEST;
	endproperty
	a_rowclk: assert property (p_rowclk) else $error("row clock without bus request");
	property p_last;
		1'b1 |=> LAST_LINE_MUX_PIN == $past(LAST_LINE_IN);
	endproperty
	a_last: assert property (p_last) else $error("last line pin not following");
	property p_ptr_rd;
		RD && ADDR == 3'h0 |=> RDATA[3:0] <= 4'he;
	endproperty
	a_ptr_rd: assert property (p_ptr_rd) else $error("init read beyond last pointer");
	c_grant: cover property ($fell(BACK));
	c_fill: cover property (MEM_WE);
	c_rowclk: cover property (ROWBUF_CLOCK);
endmodule // cba_props
bind cba_arbiter cba_props cba_props_i (.CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA,
	.BLANK_IN, .LAST_LINE_IN, .HOST_BUFFER_REQUEST, .BACK, .BUS_RELEASE_OUT,
	.ROWBUF_BUS_REQUEST, .ROWBUF_CLOCK, .LAST_LINE_MUX_PIN, .MEM_WE, .ACTIVE);

// >>> bench/cba_mem_model.sv
`timescale 1ns/1ps
module cba_mem_model (
	input wire CLOCK,
	input wire MEM_WE,
	input wire MEM_RE,
	input wire [15:0] MEM_ADDR,
	input wire [7:0] MEM_WDATA,
	output reg [7:0] MEM_RDATA
);
	reg [7:0] mem [0:255];
	reg [7:0] idle_q;
	integer k;
	initial begin
		for (k = 0; k < 256; k = k + 1) mem[k] = k[7:0];
		idle_q = 8'h5a;
	end
	// only low address bits decoded, aliasing is harmless here
	always @(posedge CLOCK) begin
		if (MEM_WE) mem[MEM_ADDR[7:0]] <= MEM_WDATA;
		idle_q <= ~idle_q;
	end
	// data stand while the read strobe does; released bus toggles so stale bytes never look valid
	always_comb MEM_RDATA = MEM_RE ? mem[MEM_ADDR[7:0]] : idle_q;
endmodule // cba_mem_model

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg CLOCK = 0, RESET = 1, WR = 0, RD = 0, BLANK_IN = 0, VBLANK_IN = 0, HBLANK_LAST2_IN = 0;
	reg HFP_START_IN = 0, ROW_LINE0_IN = 0, ROW_NEXT_IN = 0, LAST_LINE_IN = 0;
	reg HOST_BUFFER_REQUEST = 0;
	reg [2:0] ADDR = 0;
	reg [7:0] WDATA = 0;
	wire [7:0] RDATA, MEM_RDATA, MEM_WDATA;
	wire [15:0] MEM_ADDR;
	wire BACK, BUS_RELEASE_OUT, ROWBUF_BUS_REQUEST, ROWBUF_CLOCK, BLANK_FORCE, CURSOR;
	wire LAST_LINE_MUX_PIN, MEM_WE, MEM_RE, ACTIVE;
	integer bad_count = 0, checked = 0, cyc = 0, i, wes = 0, rck = 0, r0;
	reg [15:0] q [$];
	reg [15:0] e;
	reg [31:0] rn, rg;
	reg rd_q = 0;
	reg [3:0] hc = 0;
	reg [1:0] ln = 0;
	cba_arbiter cba_arbiter_i (.CLOCK, .RESET, .ADDR, .WDATA, .WR, .RD, .RDATA, .BLANK_IN,
		.VBLANK_IN, .HBLANK_LAST2_IN, .HFP_START_IN, .ROW_LINE0_IN, .ROW_NEXT_IN,
		.LAST_LINE_IN, .HOST_BUFFER_REQUEST, .MEM_RDATA, .BACK, .BUS_RELEASE_OUT,
		.ROWBUF_BUS_REQUEST, .ROWBUF_CLOCK, .BLANK_FORCE, .CURSOR, .LAST_LINE_MUX_PIN,
		.MEM_WE, .MEM_RE, .MEM_ADDR, .MEM_WDATA, .ACTIVE);
	cba_mem_model cba_mem_model_i (.CLOCK, .MEM_WE, .MEM_RE, .MEM_ADDR, .MEM_WDATA, .MEM_RDATA);
	always #5 CLOCK = ~CLOCK;
	task close_out;
		begin
			$display("checked %0d bad_count %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0) $display("verification passed");
			else $display("verification failed");
			$finish;
		end
	endtask
	task chk(input [7:0] g, input [7:0] x);
		begin
			checked = checked + 1;
			if (g !== x) begin
				bad_count = bad_count + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
			end
		end
	endtask
	// strobes stay up between calls, idle drops them
	task wr(input [2:0] a, input [7:0] d);
		begin ADDR <= a; WDATA <= d; WR <= 1'b1; RD <= 1'b0; @(posedge CLOCK); end
	endtask
	task rd(input [2:0] a, input [7:0] m, input [7:0] x);
		begin ADDR <= a; RD <= 1'b1; WR <= 1'b0; q.push_back({m, x}); @(posedge CLOCK); end
	endtask
	task idle;
		begin WR <= 1'b0; RD <= 1'b0; @(posedge CLOCK); end
	endtask
	task init(input [1:0] m);
		begin wr(3'h1, 8'h00); wr(3'h1, 8'h00); wr(3'h0, {6'h00, m}); idle; end
	endtask
	task wt(input b);
		begin
			for (i = 0; i < 40 && BACK !== b; i = i + 1) @(posedge CLOCK);
			chk({7'h00, BACK}, {7'h00, b});
		end
	endtask
	// line of 16 clocks, last seven blanked, four lines per row
	always @(posedge CLOCK) begin
		rg = $urandom;
		hc <= hc + 4'h1;
		if (hc == 4'hf) ln <= ln + 2'h1;
		BLANK_IN <= hc >= 4'h9;
		HBLANK_LAST2_IN <= hc == 4'hd;
		HFP_START_IN <= hc == 4'h9;
		ROW_LINE0_IN <= ln == 2'h0;
		ROW_NEXT_IN <= ln == 2'h3 && hc >= 4'h9;
		LAST_LINE_IN <= rg[0];
		wes <= wes + MEM_WE;
		rck <= rck + ROWBUF_CLOCK;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			bad_count = bad_count + 1;
			close_out;
		end
	end
	always @(posedge CLOCK) begin
		if (rd_q) begin
			e = q.pop_front();
			chk(RDATA & e[15:8], e[7:0]);
		end
		rd_q <= RD;
	end
	initial begin
		rn = $urandom(7680);
		repeat (3) @(posedge CLOCK);
		RESET <= 1'b0;
		@(posedge CLOCK);
		chk({4'h0, ACTIVE, ROWBUF_BUS_REQUEST, BACK, MEM_WE}, 8'h04);
		wr(3'h1, 8'h15);
		rd(3'h0, 8'h0f, 8'h00);
		wr(3'h1, 8'h00);
		rd(3'h1, 8'h80, 8'h00);
		wr(3'h1, 8'h00);
		rd(3'h1, 8'h80, 8'h80);
		for (i = 0; i < 16; i = i + 1) begin
			rn = $urandom;
			rd(3'h0, 8'h0f, (i > 14) ? 8'h0e : i[7:0]);
			wr(3'h0, (i == 0) ? 8'h02 : {1'b0, rn[6:0]});
		end
		wr(3'h1, 8'h15);
		rd(3'h0, 8'h0f, 8'h05);
		wr(3'h1, 8'h1f);
		rd(3'h0, 8'h0f, 8'h0e);
		wr(3'h1, 8'h00);
		rd(3'h0, 8'h0f, 8'h00);
		init(2'h0);
		r0 = wes;
		wr(3'h4, 8'hf8);
		wr(3'h5, 8'hff);
		wr(3'h1, 8'hbb);
		wr(3'h1, 8'h13);
		rd(3'h0, 8'h0f, 8'h03);
		idle;
		repeat (200) @(posedge CLOCK);
		rd(3'h1, 8'h20, 8'h20);
		idle;
		chk({7'h00, wes - r0 == 9}, 8'h01);
		init(2'h2);
		HOST_BUFFER_REQUEST <= 1'b1;
		wt(1'b1);
		wt(1'b0);
		chk({6'h00, BUS_RELEASE_OUT, BLANK_FORCE}, 8'h03);
		HOST_BUFFER_REQUEST <= 1'b0;
		repeat (20) @(posedge CLOCK);
		init(2'h1);
		// display on, so the grant waits for blank rather than the front porch
		wr(3'h1, 8'h3d);
		idle;
		while (hc !== 4'h0) @(posedge CLOCK);
		// request early in the line so it is seen before blank rises
		HOST_BUFFER_REQUEST <= 1'b1;
		repeat (11) @(posedge CLOCK);
		chk({7'h00, BACK}, 8'h01);
		wt(1'b0);
		HOST_BUFFER_REQUEST <= 1'b0;
		repeat (20) @(posedge CLOCK);
		init(2'h0);
		wr(3'h0, 8'h55);
		wr(3'h0, 8'h80);
		wr(3'h6, 8'h10);
		wr(3'h7, 8'h00);
		wr(3'h1, 8'h3d);
		idle;
		for (i = 0; i < 100 && CURSOR !== 1'b1; i = i + 1) @(posedge CLOCK);
		chk({7'h00, CURSOR}, 8'h01);
		// display off stops further fetches, so exactly one entry was taken
		wr(3'h1, 8'h3c);
		idle;
		repeat (4) @(posedge CLOCK);
		rd(3'h2, 8'hff, 8'h10);
		rd(3'h3, 8'hff, 8'h11);
		rd(3'h6, 8'hff, 8'h12);
		idle;
		repeat (20) @(posedge CLOCK);
		init(2'h3);
		r0 = rck;
		repeat (160) @(posedge CLOCK);
		chk({7'h00, rck > r0}, 8'h01);
		close_out;
	end
endmodule // tb_top
